// ### rtl/position_port_device.sv
// Device end of the binary position word port: up/down position counter,
// sticky error code, word framing and the flag/control handshake.
// Assumes counter pulses and error levels come from logic on the same clock,
// and a controller that keeps ctl high until it has seen the flag.
//
// Summary of operation
// - Clear-error then transfer yields full 28-bit count
// - Decimal point in 31-28, count 27-0
// - Delivered count includes 160-count preset
// - Preset 160 normal, 16 extended resolution
// - Bit 26 flags recoverable counter overflow
// - Controller reads low word after overflow status
// - Bits 25, 24 flag irrecoverable errors
// - Reference error also raises measurement error
// - Controller subtracts two to 28 on underflow; host only subtracts the preset, wrapping in 28 bits
// - Controller sends compensator update at start
// - Controller latches follow data, clears control
// - Status field ones: tolerance or error code
// - Bit 27 flags air index error
// - Word mode sends high word first
// - One handshake per command and word
`timescale 1ns/1ps
module position_port_device
  import bpw_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic ce,
  bpw_if.device link,
  input logic ext_res,
  input logic preset_load,
  input logic cnt_up,
  input logic cnt_dn,
  input logic [3:0] dec_point,
  input logic vol_err,
  input logic ref_err,
  input logic meas_err,
  input logic in_tol,
  output logic [CNT_W-1:0] count_out,
  output logic [3:0] err_flags,
  output logic [WORD_W-1:0] dest_word,
  output logic dest_load,
  output logic comp_update
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic {IDLE_S, WAIT_LOW_S} hs_state_e;

  typedef struct packed {
    hs_state_e state;
    phase_e phase;
    logic flg;
    logic [LINK_W-1:0] d2h;
    logic [WORD_W-1:0] snap;
    logic [CNT_W-1:0] count;
    logic [3:0] err;
    logic raw;
    logic [WORD_W-1:0] dest;
    logic dest_load;
    logic comp_update;
  } dev_s;

  dev_s st_ff;
  dev_s nxt_st;
  logic [CNT_W-1:0] preset;
  logic [3:0] err_set;
  logic wrap;
  logic take;
  logic [CMD_W-1:0] cmd;
  logic clear_req;
  logic [WORD_W-1:0] word;

  // ********************************************************************
  // Preset and error sources
  // ********************************************************************
  // preset by mode
  assign preset = ext_res ? PRESET_EXT : PRESET_NORMAL;

  assign wrap = (cnt_up && !cnt_dn && st_ff.count == CNT_MAX_POS) ||
                (cnt_dn && !cnt_up && st_ff.count == CNT_MIN_NEG);

  // Error events for this cycle, one bit per code position
  always_comb begin
    err_set = ERR_RESET;
    err_set[ERR_VOL] = vol_err;
    err_set[ERR_OVF] = wrap;
    err_set[ERR_REF] = ref_err;
    err_set[ERR_MEAS] = meas_err || ref_err;
  end

  // A handshake is taken when ctl is seen high in the idle state
  assign take = (st_ff.state == IDLE_S) && link.ctl;
  assign cmd = link.h2d[CMD_W-1:0];
  assign clear_req = take && (st_ff.phase == PH_CMD) && (cmd == CLEAR_ERROR_COMMAND);

  // ********************************************************************
  // Word framing
  // ********************************************************************
  // Live word, captured into snap when a transfer command arrives
  word_framer word_framer_inst (
    .dec_point(dec_point),
    .count(st_ff.count),
    .err(st_ff.err),
    .in_tol(in_tol),
    .raw(st_ff.raw),
    .word(word)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flg = 1'b0;
    nxt_st.dest_load = 1'b0;
    nxt_st.comp_update = 1'b0;

    // Position counter
    if (preset_load) begin
      nxt_st.count = preset;
    end else if (cnt_up && !cnt_dn) begin
      nxt_st.count = st_ff.count + CNT_ONE;
    end else if (cnt_dn && !cnt_up) begin
      nxt_st.count = st_ff.count - CNT_ONE;
    end

    // Sticky error code; a new event wins over a clear
    if (clear_req) begin
      nxt_st.err = err_set;
    end else begin
      nxt_st.err = st_ff.err | err_set;
    end

    // Handshake sequencer
    case (st_ff.state)
      IDLE_S: begin
        if (link.ctl) begin
          nxt_st.flg = 1'b1;
          nxt_st.state = WAIT_LOW_S;
          nxt_st.phase = next_phase(st_ff.phase, cmd);
          case (st_ff.phase)
            PH_CMD: begin
              if (cmd == CLEAR_ERROR_COMMAND) begin
                nxt_st.raw = 1'b1;
              end else if (cmd == TRANSFER_POSITION_COMMAND) begin
                nxt_st.snap = word;
                nxt_st.raw = 1'b0;
              end else if (cmd == COMPENSATOR_UPDATE_COMMAND) begin
                nxt_st.comp_update = 1'b1;
              end
            end
            PH_RD_HI: begin
              nxt_st.d2h = st_ff.snap[WORD_W-1:LINK_W];
            end
            PH_RD_LO: begin
              nxt_st.d2h = st_ff.snap[LINK_W-1:0];
            end
            PH_WR_HI: begin
              nxt_st.dest[WORD_W-1:LINK_W] = link.h2d;
            end
            default: begin
              nxt_st.dest[LINK_W-1:0] = link.h2d;
              nxt_st.dest_load = 1'b1;
            end
          endcase
        end
      end
      default: begin
        if (!link.ctl) begin
          nxt_st.state = IDLE_S;
        end
      end
    endcase
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  // Synchronous reset; ce low freezes everything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.count <= PRESET_NORMAL;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign link.flg = st_ff.flg;
  assign link.d2h = st_ff.d2h;
  assign count_out = st_ff.count;
  assign err_flags = st_ff.err;
  assign dest_word = st_ff.dest;
  assign dest_load = st_ff.dest_load;
  assign comp_update = st_ff.comp_update;

endmodule

// ### common/bpw_pkg.sv
// Shared constants, types and the phase sequencer of the binary position word port.
// Assumes both ends and their user logic run on one 20 MHz clock.
package bpw_pkg;

  // ********************************************************************
  // Widths and field positions
  // ********************************************************************
  localparam int WORD_W = 32;
  localparam int LINK_W = 16;
  localparam int CNT_W = 28;
  localparam int CMD_W = 8;
  localparam int DEC_LSB = 28;  // Decimal point / status field, bits 31-28
  localparam int CODE_LSB = 24; // Error code field, bits 27-24
  localparam int ERR_VOL = 3;   // Air index error, bit 27
  localparam int ERR_OVF = 2;   // Counter overflow, bit 26
  localparam int ERR_REF = 1;   // Reference error, bit 25
  localparam int ERR_MEAS = 0;  // Measurement error, bit 24

  // ********************************************************************
  // Values
  // ********************************************************************
  localparam logic [3:0] STATUS_MARK = 4'hf;  // Decimal field of a status word
  localparam logic [3:0] CODE_IN_TOL = 4'hf;  // Code field meaning within tolerance
  localparam logic [CNT_W-1:0] PRESET_NORMAL = 28'h00000a0;  // 160 counts
  localparam logic [CNT_W-1:0] PRESET_EXT = 28'h0000010;     // 16 counts
  localparam logic [CNT_W-1:0] CNT_MAX_POS = 28'h7ffffff;
  localparam logic [CNT_W-1:0] CNT_MIN_NEG = 28'h8000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 28'h0000001;
  localparam logic [3:0] ERR_RESET = 4'h0;

  // ********************************************************************
  // Command codes, sent in the low byte of the host word
  // ********************************************************************
  localparam logic [CMD_W-1:0] CLEAR_ERROR_COMMAND = 8'hf0;
  localparam logic [CMD_W-1:0] TRANSFER_POSITION_COMMAND = 8'h03;
  localparam logic [CMD_W-1:0] COMPENSATOR_UPDATE_COMMAND = 8'h60;
  localparam logic [CMD_W-1:0] LOAD_DESTINATION_COMMAND = 8'h04;

  // ********************************************************************
  // Handshake phases
  // ********************************************************************
  typedef enum logic [2:0] {PH_CMD, PH_RD_HI, PH_RD_LO, PH_WR_HI, PH_WR_LO} phase_e;

  // Phase of the handshake that follows one in phase ph
  function automatic phase_e next_phase(input phase_e ph, input logic [CMD_W-1:0] cmd);
    phase_e res;
    res = PH_CMD;
    case (ph)
      PH_CMD: begin
        if (cmd == TRANSFER_POSITION_COMMAND) begin
          res = PH_RD_HI;
        end else if (cmd == LOAD_DESTINATION_COMMAND) begin
          res = PH_WR_HI;
        end
      end
      PH_RD_HI: res = PH_RD_LO;
      PH_WR_HI: res = PH_WR_LO;
      default: res = PH_CMD;
    endcase
    return res;
  endfunction

endpackage

// ### common/bpw_if.sv
// Flag/control link between the system controller and the position port.
// Assumes both parties share the clock; ctl and flg are plain levels.
`timescale 1ns/1ps
interface bpw_if;
  import bpw_pkg::*;

  logic ctl;               // Controller request, high until flag seen
  logic flg;               // Device flag, one-cycle pulse
  logic [LINK_W-1:0] h2d;  // Command or data word toward the device
  logic [LINK_W-1:0] d2h;  // Position word toward the controller

  modport device (input ctl, input h2d, output flg, output d2h);
  modport host (output ctl, output h2d, input flg, input d2h);
endinterface

// ### rtl/word_framer.sv
// Builds the 32-bit output word from count, decimal point and error state.
// Assumes purely combinational use inside the device end.
`timescale 1ns/1ps
module word_framer
  import bpw_pkg::*;
(
  input logic [3:0] dec_point,
  input logic [CNT_W-1:0] count,
  input logic [3:0] err,
  input logic in_tol,
  input logic raw,
  output logic [WORD_W-1:0] word
);

  // ********************************************************************
  // Word assembly
  // ********************************************************************
  // Status words replace the decimal field by all ones
  always_comb begin
    word = {dec_point, count};
    if (!raw && err != ERR_RESET) begin
      word = {STATUS_MARK, ~err, count[CODE_LSB-1:0]};
    end else if (!raw && in_tol) begin
      word = {STATUS_MARK, CODE_IN_TOL, count[CODE_LSB-1:0]};
    end
  end

endmodule

// ### rtl/position_port_host.sv
// Controller end of the binary position word port: runs command, read and
// write handshakes and decodes position words.
// Assumes a device on the same clock that answers each ctl with one flag.
`timescale 1ns/1ps
module position_port_host
  import bpw_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic ce,
  bpw_if.host link,
  input logic ext_res,
  input logic comp_present,
  input logic cmd_valid,
  input logic [CMD_W-1:0] cmd_code,
  input logic [WORD_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [WORD_W-1:0] rsp_word,
  output logic [CNT_W-1:0] rsp_pos,
  output logic [3:0] rsp_dec,
  output logic rsp_status
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {BOOT_S, IDLE_S, HS_S, GAP_S} host_state_e;

  typedef struct packed {
    host_state_e state;
    phase_e phase;
    logic [CMD_W-1:0] cmd;
    logic ctl;
    logic [LINK_W-1:0] h2d;
    logic [WORD_W-1:0] wdata;
    logic [LINK_W-1:0] latch;
    logic [LINK_W-1:0] hi;
    logic cmd_ready;
    logic rsp_valid;
    logic [WORD_W-1:0] rsp_word;
    logic [CNT_W-1:0] rsp_pos;
    logic [3:0] rsp_dec;
    logic rsp_status;
  } host_s;

  host_s st_ff;
  host_s nxt_st;
  logic [CNT_W-1:0] preset;
  logic [WORD_W-1:0] word;

  assign preset = ext_res ? PRESET_EXT : PRESET_NORMAL;
  assign word = {st_ff.hi, link.d2h};

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    if (st_ff.ctl) begin
      nxt_st.latch = link.d2h;
    end
    case (st_ff.state)
      BOOT_S: begin
        nxt_st.phase = PH_CMD;
        if (comp_present) begin
          nxt_st.cmd = COMPENSATOR_UPDATE_COMMAND;
          nxt_st.h2d = {8'h00, COMPENSATOR_UPDATE_COMMAND};
          nxt_st.ctl = 1'b1;
          nxt_st.state = HS_S;
        end else begin
          nxt_st.cmd_ready = 1'b1;
          nxt_st.state = IDLE_S;
        end
      end
      IDLE_S: begin
        if (cmd_valid) begin
          nxt_st.cmd = cmd_code;
          nxt_st.wdata = cmd_wdata;
          nxt_st.h2d = {8'h00, cmd_code};
          nxt_st.ctl = 1'b1;
          nxt_st.cmd_ready = 1'b0;
          nxt_st.phase = PH_CMD;
          nxt_st.state = HS_S;
        end
      end
      HS_S: begin
        if (link.flg) begin
          nxt_st.ctl = 1'b0;
          nxt_st.state = GAP_S;
          nxt_st.phase = next_phase(st_ff.phase, st_ff.cmd);
          if (st_ff.phase == PH_RD_HI) begin
            nxt_st.hi = link.d2h;
          end else if (st_ff.phase == PH_RD_LO) begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_word = word;
            nxt_st.rsp_dec = word[WORD_W-1:DEC_LSB];
            nxt_st.rsp_status = (word[WORD_W-1:DEC_LSB] == STATUS_MARK);
            nxt_st.rsp_pos = word[CNT_W-1:0] - preset;
          end
        end
      end
      default: begin
        if (st_ff.phase == PH_CMD) begin
          nxt_st.cmd_ready = 1'b1;
          nxt_st.state = IDLE_S;
        end else begin
          nxt_st.ctl = 1'b1;
          nxt_st.state = HS_S;
          if (st_ff.phase == PH_WR_HI) begin
            nxt_st.h2d = st_ff.wdata[WORD_W-1:LINK_W];
          end else if (st_ff.phase == PH_WR_LO) begin
            nxt_st.h2d = st_ff.wdata[LINK_W-1:0];
          end
        end
      end
    endcase
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign link.ctl = st_ff.ctl;
  assign link.h2d = st_ff.h2d;
  assign cmd_ready = st_ff.cmd_ready;
  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_word = st_ff.rsp_word;
  assign rsp_pos = st_ff.rsp_pos;
  assign rsp_dec = st_ff.rsp_dec;
  assign rsp_status = st_ff.rsp_status;

endmodule

// ### tb/binary_position_word_port_checker.sv
// Concurrent checks on the flag/control link between host and device ends.
// Assumes one clock, a synchronous active-low reset and the bpw_if signals.
`timescale 1ns/1ps
module binary_position_word_port_checker
  import bpw_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic ctl,
  input logic flg,
  input logic [LINK_W-1:0] h2d,
  input logic [LINK_W-1:0] d2h
);
  // ********************************************************************
  // Data handshakes still owed after a command
  // ********************************************************************
  logic [1:0] data_left_ff;

  // Counts down the two data handshakes of a transfer or a load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_left_ff <= 2'h0;
    end else if (flg) begin
      if (data_left_ff != 2'h0) begin
        data_left_ff <= data_left_ff - 2'h1;
      end else if (h2d[7:0] == TRANSFER_POSITION_COMMAND || h2d[7:0] == LOAD_DESTINATION_COMMAND) begin
        data_left_ff <= 2'h2;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Handshake timing and hold checks
  a_flag_follows_ctl: assert property ($rose(ctl) |=> flg ##1 !ctl)
    else $error("flag did not answer control in one cycle");
  a_flag_pulse_gap: assert property (flg |=> !flg [*2])
    else $error("flag longer than one cycle or too close");
  a_no_stray_flag: assert property (flg |-> $past(ctl))
    else $error("flag without a control request");
  a_ctl_held_wait: assert property (ctl && !flg |=> ctl)
    else $error("control dropped before flag");
  a_ctl_clear_flag: assert property (flg |-> ctl ##1 !ctl)
    else $error("control not cleared after flag");
  a_h2d_hold: assert property (ctl && $past(ctl) |-> $stable(h2d))
    else $error("host word moved during request");
  a_d2h_only_flag: assert property ($changed(d2h) |-> flg)
    else $error("device word moved outside a flag");
  a_cmd_upper_zero: assert property (flg && data_left_ff == 2'h0 |-> h2d[15:8] == 8'h00)
    else $error("command word upper byte not zero");

  // Main scenarios
  c_command: cover property (flg && data_left_ff == 2'h0);
  c_first_data: cover property (flg && data_left_ff == 2'h2);
  c_second_data: cover property (flg && data_left_ff == 2'h1);
endmodule

// ### tb/tb_binary_position_word_port.sv
// Self-checking bench: host and device ends joined by bpw_if.
// Assumes bpw_pkg, bpw_if and both design ends compiled before it.
`timescale 1ns/1ps
module tb_binary_position_word_port;
  import bpw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic ext_res = 1'b0;
  logic preset_load = 1'b0;
  logic cnt_up = 1'b0;
  logic cnt_dn = 1'b0;
  logic [3:0] dec_point = 4'h0;
  logic vol_err = 1'b0;
  logic ref_err = 1'b0;
  logic meas_err = 1'b0;
  logic in_tol = 1'b0;
  logic cmd_valid = 1'b0;
  logic [CMD_W-1:0] cmd_code = 8'h00;
  logic [WORD_W-1:0] cmd_wdata = 32'h0;
  logic cmd_ready, rsp_valid, rsp_status, dest_load, comp_update;
  logic [WORD_W-1:0] rsp_word, dest_word, w;
  logic [CNT_W-1:0] rsp_pos, count_out, m_cnt;
  logic [3:0] rsp_dec, err_flags, m_err;
  logic m_raw;
  int n_errors = 0;
  int checks_done = 0;
  int n_comp = 0;
  int n_dest = 0;

  always #25 clk = ~clk;

  // ********************************************************************
  // Both ends across one link
  // ********************************************************************
  bpw_if link ();
  position_port_device position_port_device_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .link(link), .ext_res(ext_res), .preset_load(preset_load), .cnt_up(cnt_up),
    .cnt_dn(cnt_dn), .dec_point(dec_point), .vol_err(vol_err), .ref_err(ref_err),
    .meas_err(meas_err), .in_tol(in_tol), .count_out(count_out), .err_flags(err_flags),
    .dest_word(dest_word), .dest_load(dest_load), .comp_update(comp_update));
  position_port_host position_port_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .link(link), .ext_res(ext_res), .comp_present(1'b1), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_pos(rsp_pos), .rsp_dec(rsp_dec),
    .rsp_status(rsp_status));
  binary_position_word_port_checker binary_position_word_port_checker_inst (.clk(clk),
    .rst_n(rst_n), .ctl(link.ctl), .flg(link.flg), .h2d(link.h2d), .d2h(link.d2h));

  // Pulse counters for one-cycle outputs
  always @(posedge clk) begin
    if (comp_update === 1'b1) n_comp++;
    if (dest_load === 1'b1) n_dest++;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Word the device should frame from the bench's own state
  function automatic logic [31:0] exp_word(input logic [3:0] e, input logic tol, input logic raw);
    if (raw || (e == 4'h0 && !tol)) return {dec_point, m_cnt};
    if (e != 4'h0) return {STATUS_MARK, ~e, m_cnt[23:0]};
    return {STATUS_MARK, CODE_IN_TOL, m_cnt[23:0]};
  endfunction

  // Issue one user command once the host is ready; starts and ends at a falling edge
  task automatic run_cmd(input logic [7:0] code, input logic [31:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmp(cmd_ready, 1, "ready");
    cmd_code = code;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic xfer();
    int n;
    w = exp_word(m_err, in_tol, m_raw);
    m_raw = 1'b0;
    run_cmd(TRANSFER_POSITION_COMMAND, 32'h0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp(rsp_valid, 1, "rsp valid");
    cmp(rsp_word, w, "word");
    cmp(rsp_pos, CNT_W'(w[27:0] - (ext_res ? PRESET_EXT : PRESET_NORMAL)), "pos");
    cmp(rsp_dec, w[31:28], "dec");
    cmp(rsp_status, w[31:28] == STATUS_MARK, "status");
  endtask

  task automatic tick(input logic up, input logic dn);
    cnt_up = up;
    cnt_dn = dn;
    @(negedge clk);
    if (up && !dn) m_cnt = m_cnt + CNT_ONE;
    if (dn && !up) m_cnt = m_cnt - CNT_ONE;
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
  endtask

  task automatic reload(input logic ext);
    ext_res = ext;
    preset_load = 1'b1;
    @(negedge clk);
    preset_load = 1'b0;
    m_cnt = ext ? PRESET_EXT : PRESET_NORMAL;
    cmp(count_out, m_cnt, "preset");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    void'($urandom(60));
    m_cnt = PRESET_NORMAL;
    m_err = 4'h0;
    m_raw = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    xfer();
    cmp(n_comp, 1, "boot update");
    $display("test boot done");
    repeat (200) tick(1'b0, 1'b1);
    xfer();
    repeat (8) begin
      repeat ($urandom_range(40)) tick(1'($urandom_range(1)), 1'($urandom_range(1)));
      dec_point = 4'($urandom_range(14));
      xfer();
      cmp(count_out, m_cnt, "count");
    end
    $display("test count done");
    for (int k = 0; k < 3; k++) begin
      vol_err = (k == 0);
      ref_err = (k == 1);
      meas_err = (k == 2);
      @(negedge clk);
      {vol_err, ref_err, meas_err} = 3'h0;
      m_err = (k == 0) ? 4'h8 : (k == 1) ? 4'h3 : 4'h1;
      cmp(err_flags, m_err, "flags");
      xfer();
      run_cmd(CLEAR_ERROR_COMMAND, 32'h0);
      m_err = 4'h0;
      m_raw = 1'b1;
      repeat (2) @(negedge clk);
      cmp(err_flags, 4'h0, "cleared");
      xfer();
    end
    in_tol = 1'b1;
    xfer();
    m_raw = 1'b1;
    run_cmd(CLEAR_ERROR_COMMAND, 32'h0);
    xfer();
    in_tol = 1'b0;
    $display("test errors done");
    reload(1'b1);
    xfer();
    reload(1'b0);
    xfer();
    repeat (3) begin
      w = $urandom;
      run_cmd(LOAD_DESTINATION_COMMAND, w);
      repeat (10) @(negedge clk);
      cmp(dest_word, w, "dest");
    end
    cmp(n_dest, 3, "dest loads");
    $display("test load done");
    // Clock enable low freezes both ends, counter pulses included
    ce = 1'b0;
    cnt_up = 1'b1;
    repeat (5) @(negedge clk);
    cnt_up = 1'b0;
    ce = 1'b1;
    cmp(count_out, m_cnt, "frozen count");
    xfer();
    $display("test enable done");
    complete_run();
  end
endmodule
